// >>> logic/pst_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Read data come from a register; full when both slots hold data.
`timescale 1ns/1ps
module pst_buf2 #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic      [W-1:0] out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);

	logic [W-1:0] slot_reg;
	logic         slot_v_reg;
	logic [W-1:0] head_reg;
	logic         head_v_reg;
	logic         push;
	logic         pop;

	// Handshakes
	assign in_ready  = !slot_v_reg;
	assign out_valid = head_v_reg;
	assign out_data  = head_reg;
	assign push      = in_valid && in_ready;
	assign pop       = head_v_reg && out_ready;

	// Head holds the oldest word, slot the second
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			head_reg   <= '0;
			head_v_reg <= 1'b0;
			slot_reg   <= '0;
			slot_v_reg <= 1'b0;
		end else begin
			if (!head_v_reg || pop) begin
				if (slot_v_reg) begin
					head_reg   <= slot_reg;
					head_v_reg <= 1'b1;
					slot_v_reg <= push;
					slot_reg   <= in_data;
				end else begin
					head_reg   <= in_data;
					head_v_reg <= push;
				end
			end else if (push) begin
				slot_reg   <= in_data;
				slot_v_reg <= 1'b1;
			end
		end
	end

endmodule : pst_buf2

// >>> logic/pst_pkg.sv
// Purpose: Shared constants and types for the passive panel sync timing block.
// Assumes: sys_clk is the system bus clock and runs at SYS_CLK_HZ.
// Notes:   Every count used by the timing logic is defined here once.
package pst_pkg;

	// Clock figures
	localparam int SYS_CLK_HZ     = 50_000_000;
	localparam int PCC_MAX_HZ     = 48_000_000;
	localparam int PCC_MIN_DIV    = (SYS_CLK_HZ + PCC_MAX_HZ - 1) / PCC_MAX_HZ;
	localparam int SHIFT_MIN_CYC  = 5;

	// Extra pixel periods added to each programmed interval
	localparam int LEND_EXTRA     = 1;
	localparam int LSYNC_EXTRA    = 1;
	localparam int LSTART_EXTRA   = 2;

	// Field widths
	localparam int PDIV_W         = 4;
	localparam int PCD_W          = 6;
	localparam int WAIT_W         = 8;
	localparam int CNT_W          = 10;
	localparam int TPIX_W         = 11;
	localparam int SP_W           = 15;
	localparam int STC_W          = 20;
	localparam int DATA_W         = 8;

	// Reset values
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	// Line sequencer states
	typedef enum logic [2:0] {
		PST_IDLE,
		PST_LEND,
		PST_LSYNC,
		PST_LSTART,
		PST_SHIFT
	} pst_state_t;

endpackage : pst_pkg

// >>> logic/pst_timing.sv
// Purpose: Line sync, frame sync and shift clock timing for a passive panel.
// Assumes: Settings are stable while enable is high; data arrive on sys_clk.
// Notes:   All pin outputs are registered and lag the sequencer by one cycle.
// Notes on behaviour
// - Line sync end to frame sync edge lasts line_start_wait plus 2 pixel periods.
// - Line sync stays active line_sync_width plus 1 pixel periods.
// - After the last shift clock wait line_end_wait plus 1 pixel periods.
// - First shift clock active edge within one shift period of frame sync.
// - Pixel period is controller clock period times divider plus 1.
// - Shift period is pixel period times the panel data bus width.
// - Frame sync, line sync and shift clock each have selectable polarity.
// - Shift clock must not exceed one fifth of the system clock.
// - Panel controller clock must not exceed 48 MHz.
`timescale 1ns/1ps
module pst_timing
	import pst_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              enable,
	input  wire logic [PDIV_W-1:0] periph_div,
	input  wire logic [PCD_W-1:0]  pixel_clock_divider,
	input  wire logic [1:0]        bus_width_sel,
	input  wire logic [WAIT_W-1:0] line_end_wait,
	input  wire logic [WAIT_W-1:0] line_start_wait,
	input  wire logic [WAIT_W-1:0] line_sync_width,
	input  wire logic [CNT_W-1:0]  line_groups,
	input  wire logic [CNT_W-1:0]  frame_lines,
	input  wire logic              frame_pol_low,
	input  wire logic              line_pol_low,
	input  wire logic              shift_pol_low,
	input  wire logic [DATA_W-1:0] pix_data,
	input  wire logic              pix_valid,
	output logic                   pix_ready,
	output logic                   line_sync,
	output logic                   frame_sync,
	output logic                   shift_clk,
	output logic [DATA_W-1:0]      panel_data_bus,
	output logic                   cfg_err,
	output logic                   underrun,
	output logic                   busy
);

	pst_state_t        state_reg;
	pst_state_t        state_next;
	logic [TPIX_W-1:0] div_cnt_reg;
	logic [WAIT_W:0]   cnt_reg;
	logic [SP_W-1:0]   sc_reg;
	logic [CNT_W-1:0]  grp_reg;
	logic [CNT_W-1:0]  line_reg;
	logic              frame_act_reg;
	logic              frame_act_next;
	logic              line_sync_reg;
	logic              frame_sync_reg;
	logic              shift_clk_reg;
	logic [DATA_W-1:0] pd_reg;
	logic              underrun_reg;
	logic              cfg_err_reg;
	logic              busy_reg;
	logic [STC_W-1:0]  st_cyc_reg;

	logic [TPIX_W-1:0] tpix;
	logic [3:0]        bus_w;
	logic [SP_W-1:0]   sp;
	logic              bad_pcc;
	logic              bad_shift;
	logic              err_w;
	logic              pix_tick;
	logic [WAIT_W:0]   n_lend;
	logic [WAIT_W:0]   n_lsync;
	logic [WAIT_W:0]   n_lstart;
	logic [WAIT_W:0]   n_cur;
	logic              in_shift;
	logic              per_end;
	logic              line_done;
	logic              last_line;
	logic              step_done;
	logic              pop;
	logic              shift_act;
	logic [DATA_W-1:0] buf_data;
	logic              buf_valid;

	assign tpix  = (TPIX_W'(periph_div) + 11'h001) * (TPIX_W'(pixel_clock_divider) + 11'h001);
	// shift period, widened before the shift so no bit is lost
	assign bus_w = 4'h1 << bus_width_sel;
	assign sp    = SP_W'(tpix) << bus_width_sel;

	assign bad_pcc   = (({1'b0, periph_div} + 5'h01) < 5'(PCC_MIN_DIV));
	assign bad_shift = (sp < SP_W'(SHIFT_MIN_CYC));
	assign err_w     = bad_pcc || bad_shift;

	// Interval lengths in pixel periods
	assign n_lend   = {1'b0, line_end_wait} + 9'(LEND_EXTRA);
	assign n_lsync  = {1'b0, line_sync_width} + 9'(LSYNC_EXTRA);
	assign n_lstart = {1'b0, line_start_wait} + 9'(LSTART_EXTRA);
	assign n_cur    = (state_reg == PST_LEND)  ? n_lend :
	                  (state_reg == PST_LSYNC) ? n_lsync : n_lstart;

	// Sequencer decode
	assign pix_tick  = (div_cnt_reg >= tpix - 11'h001);
	assign in_shift  = (state_reg == PST_SHIFT);
	assign per_end   = in_shift && (sc_reg >= sp - 15'h0001);
	assign line_done = per_end && (grp_reg >= line_groups);
	assign last_line = (line_reg >= frame_lines);
	assign step_done = pix_tick && (cnt_reg >= n_cur - 9'h001);
	// data advance only at shift period start
	assign pop       = in_shift && (sc_reg == '0);
	// active half of each shift period
	assign shift_act = in_shift && (sc_reg >= (sp >> 1));

	// Next state
	always_comb begin
		state_next = state_reg;
		if (!enable || err_w) begin
			state_next = PST_IDLE;
		end else begin
			case (state_reg)
				PST_IDLE:   if (pix_tick) state_next = PST_LEND;
				PST_LEND:   if (step_done) state_next = PST_LSYNC;
				PST_LSYNC:  if (step_done) state_next = PST_LSTART;
				PST_LSTART: if (step_done) state_next = PST_SHIFT;
				PST_SHIFT:  if (line_done) state_next = PST_LEND;
				default:    state_next = PST_IDLE;
			endcase
		end
	end

	// frame sync edge at end of first line start wait
	assign frame_act_next = (state_reg == PST_LSTART && state_next == PST_SHIFT
	                         && line_reg == '0) ? 1'b1 :
	                        (state_next != PST_SHIFT) ? 1'b0 : frame_act_reg;

	// Sequencer state and frame marker
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg     <= PST_IDLE;
			frame_act_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			frame_act_reg <= frame_act_next;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_reg <= '0;
		end else begin
			div_cnt_reg <= pix_tick ? '0 : div_cnt_reg + 11'h001;
		end
	end

	// pixel periods spent in the current wait
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
		end else if (state_next != state_reg) begin
			cnt_reg <= '0;
		end else if (pix_tick) begin
			cnt_reg <= cnt_reg + 9'h001;
		end
	end

	// position within the shift period and the line
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sc_reg  <= '0;
			grp_reg <= '0;
		end else if (!in_shift || state_next != PST_SHIFT) begin
			sc_reg  <= '0;
			grp_reg <= '0;
		end else if (per_end) begin
			sc_reg  <= '0;
			grp_reg <= grp_reg + 10'h001;
		end else begin
			sc_reg  <= sc_reg + 15'h0001;
		end
	end

	// Line counter wraps at the end of the frame
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			line_reg <= '0;
		end else if (state_next == PST_IDLE) begin
			line_reg <= '0;
		end else if (line_done) begin
			line_reg <= last_line ? '0 : line_reg + 10'h001;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			line_sync_reg  <= 1'b0;
			frame_sync_reg <= 1'b0;
			shift_clk_reg  <= 1'b0;
		end else begin
			line_sync_reg  <= (state_reg == PST_LSYNC) ^ line_pol_low;
			frame_sync_reg <= frame_act_reg ^ frame_pol_low;
			shift_clk_reg  <= shift_act ^ shift_pol_low;
		end
	end

	// data group taken at each shift period start
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pd_reg       <= DATA_RST;
			underrun_reg <= 1'b0;
		end else begin
			underrun_reg <= pop && !buf_valid;
			if (pop) begin
				pd_reg <= buf_valid ? buf_data : DATA_RST;
			end
		end
	end

	// Status flags
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_err_reg <= 1'b0;
			busy_reg    <= 1'b0;
		end else begin
			cfg_err_reg <= err_w;
			busy_reg    <= (state_reg != PST_IDLE);
		end
	end

	// Cycles spent in the current state, for checking only
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_cyc_reg <= '0;
		end else begin
			st_cyc_reg <= (state_next != state_reg) ? '0 : st_cyc_reg + 20'h00001;
		end
	end

	// Two-entry buffer in the data path
	pst_buf2 #(
		.W (DATA_W)
	) u_buf (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_data   (pix_data),
		.in_valid  (pix_valid),
		.in_ready  (pix_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (pop)
	);

	// Pin outputs
	assign line_sync      = line_sync_reg;
	assign frame_sync     = frame_sync_reg;
	assign shift_clk      = shift_clk_reg;
	assign panel_data_bus = pd_reg;
	assign cfg_err        = cfg_err_reg;
	assign underrun       = underrun_reg;
	assign busy           = busy_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_start_wait_len: assert property (
		state_reg == PST_LSTART && state_next == PST_SHIFT
		|-> st_cyc_reg == STC_W'(n_lstart * tpix - 1)
	) else $error("line start wait length wrong");

	a_sync_pulse_len: assert property (
		state_reg == PST_LSYNC && state_next == PST_LSTART
		|-> st_cyc_reg == STC_W'(n_lsync * tpix - 1)
	) else $error("line sync width wrong");

	a_end_wait_len: assert property (
		state_reg == PST_LEND && state_next == PST_LSYNC
		|-> st_cyc_reg == STC_W'(n_lend * tpix - 1)
	) else $error("line end wait length wrong");

	a_frame_to_shift: assert property (
		$rose(frame_act_reg) |-> in_shift && sc_reg == '0
	) else $error("frame sync not at shift start");

	a_pix_tick_gap: assert property (
		pix_tick && !$stable(tpix) == 1'b0 |-> div_cnt_reg == tpix - 11'h001
	) else $error("pixel period wrong");

	a_shift_period: assert property (
		per_end |-> sc_reg == sp - 15'h0001 ##1 (!in_shift || sc_reg == '0)
	) else $error("shift period wrong");

	a_line_pol_pin: assert property (
		$stable(line_pol_low) |=>
			line_sync == (($past(state_reg) == PST_LSYNC) ^ $past(line_pol_low))
	) else $error("line sync polarity wrong");

	// bad settings hold the sequencer idle
	a_cfg_halt: assert property (
		err_w |=> state_reg == PST_IDLE && cfg_err
	) else $error("bad clock settings not halted");

	// data change only at period start and shift idle outside shifting
	a_data_sync: assert property (
		!$stable(panel_data_bus) |-> $past(pop)
	) else $error("panel data changed off shift edge");

	a_shift_idle: assert property (
		!in_shift |=> shift_clk == $past(shift_pol_low)
	) else $error("shift clock not idle");

	c_frame_start: cover property ($rose(frame_act_reg));
	c_line_wrap: cover property (line_done && last_line);
	c_underrun: cover property (underrun);
	c_cfg_bad: cover property (err_w && enable);

endmodule : pst_timing

// >>> test/pst_panel_model.sv
// Purpose: Behavioural passive panel that samples data groups on the shift clock.
// Assumes: Its polarity inputs carry the same settings as the timing block's.
// Notes:   Edge pulses are registered, so they all lag the pins by one cycle alike.
`timescale 1ns/1ps
module pst_panel_model
	import pst_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              line_sync,
	input  wire logic              frame_sync,
	input  wire logic              shift_clk,
	input  wire logic [DATA_W-1:0] panel_data_bus,
	input  wire logic              frame_pol_low,
	input  wire logic              line_pol_low,
	input  wire logic              shift_pol_low,
	output logic      [3:0]        edge_ev,
	output logic                   cap_valid,
	output logic      [DATA_W-1:0] cap_data
);
	logic [2:0] lvl;
	logic [2:0] lvl_reg;

	// Strip the programmed polarity so that active always reads high
	assign lvl = {frame_sync ^ frame_pol_low, line_sync ^ line_pol_low, shift_clk ^ shift_pol_low};

	// Edges {frame rise, line fall, line rise, shift fall}; a group is taken on shift rise
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lvl_reg   <= 3'h0;
			edge_ev   <= 4'h0;
			cap_valid <= 1'b0;
			cap_data  <= DATA_RST;
		end else begin
			lvl_reg   <= lvl;
			edge_ev   <= {lvl[2] & ~lvl_reg[2], ~lvl[1] & lvl_reg[1], lvl[1] & ~lvl_reg[1],
				~lvl[0] & lvl_reg[0]};
			cap_valid <= lvl[0] & ~lvl_reg[0];
			cap_data  <= panel_data_bus;
		end
	end
endmodule : pst_panel_model

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the passive panel sync timing block.
// Assumes: Settings and polarities change only while enable is low.
// Notes:   Each run ends by starving the buffer, so no group is cut mid-period.
`timescale 1ns/1ps
module tb_top
	import pst_pkg::*;
;
	logic              sys_clk = 1'b0;
	logic              resetn = 1'b0;
	logic              enable = 1'b0;
	logic [PDIV_W-1:0] periph_div = 4'h1;
	logic [PCD_W-1:0]  pixel_clock_divider = 6'h00;
	logic [1:0]        bus_width_sel = 2'h2;
	logic [WAIT_W-1:0] line_end_wait = 8'h00;
	logic [WAIT_W-1:0] line_start_wait = 8'h00;
	logic [WAIT_W-1:0] line_sync_width = 8'h00;
	logic [CNT_W-1:0]  line_groups = 10'h003;
	logic [CNT_W-1:0]  frame_lines = 10'h001;
	logic [2:0]        pol = 3'h0;
	logic [DATA_W-1:0] pix_data = 8'h00;
	logic              pix_valid = 1'b0;
	logic              pix_ready, line_sync, frame_sync, shift_clk, cfg_err, underrun, busy;
	logic [DATA_W-1:0] panel_data_bus, cap_data, last_data;
	logic [3:0]        edge_ev;
	logic              cap_valid, acc, feed_on = 1'b0, chk_on = 1'b0;
	logic [DATA_W-1:0] exp_q[$];
	logic [12:0]       lim[3] = '{{4'h0, 6'h03, 2'h3, 1'b1}, {4'h3, 6'h00, 2'h0, 1'b1},
		{4'h4, 6'h00, 2'h0, 1'b0}};
	int                failures = 0, cmp_count = 0, cyc = 0, zero_pend = 0, seed = 32'h810a;
	int                tpix, ts, k, fs_pend, t_cfg, t_lr, t_lf, t_fr, t_sf, t_sr;

	pst_timing pst_timing_inst (
		.sys_clk, .resetn, .enable, .periph_div, .pixel_clock_divider, .bus_width_sel,
		.line_end_wait, .line_start_wait, .line_sync_width, .line_groups, .frame_lines,
		.frame_pol_low(pol[2]), .line_pol_low(pol[1]), .shift_pol_low(pol[0]),
		.pix_data, .pix_valid, .pix_ready, .line_sync, .frame_sync, .shift_clk,
		.panel_data_bus, .cfg_err, .underrun, .busy
	);
	pst_panel_model pst_panel_model_inst (
		.sys_clk, .resetn, .line_sync, .frame_sync, .shift_clk, .panel_data_bus,
		.frame_pol_low(pol[2]), .line_pol_low(pol[1]), .shift_pol_low(pol[0]),
		.edge_ev, .cap_valid, .cap_data
	);

	always #10 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	// Prime the buffer, stream for n cycles, starve until a group goes empty, stop
	task automatic run_cfg(input int n);
		tpix = (periph_div + 1) * (pixel_clock_divider + 1);
		ts = tpix << bus_width_sel;
		feed_on = 1'b1;
		step(4);
		check(pix_ready, exp_q.size() < 2);
		t_cfg = cyc;
		enable = 1'b1;
		chk_on = 1'b1;
		step(n);
		check({cfg_err, busy}, 2'b01);
		feed_on = 1'b0;
		k = 0;
		while (underrun !== 1'b1 && k < 4000) begin
			@(posedge sys_clk);
			k++;
		end
		check(k < 4000, 1'b1);
		// Let the zero group that followed the underrun reach the panel
		step(ts + 4);
		check(exp_q.size(), 0);
		enable = 1'b0;
		chk_on = 1'b0;
		step(3);
		zero_pend = 0;
		check({frame_sync, line_sync, shift_clk, busy}, {pol, 1'b0});
	endtask : run_cfg

	// Random groups with random gaps; a refused group is held until taken
	always @(posedge sys_clk) begin
		acc = pix_valid && pix_ready === 1'b1;
		if (acc) exp_q.push_back(pix_data);
		#1;
		if (acc || !pix_valid) begin
			pix_data = 8'($random(seed));
			pix_valid = feed_on && ($random(seed) & 3) != 0;
		end
	end

	// Score groups seen by the panel and time the sync edges
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			report_and_stop();
		end
		if (underrun === 1'b1) zero_pend++;
		if (edge_ev[0]) t_sf = cyc;
		if (edge_ev[1]) begin
			if (chk_on && t_sf > t_cfg) check(cyc - t_sf, (line_end_wait + 1) * tpix);
			t_lr = cyc;
		end
		if (edge_ev[2]) begin
			if (chk_on && t_lr > t_cfg) check(cyc - t_lr, (line_sync_width + 1) * tpix);
			t_lf = cyc;
		end
		if (edge_ev[3] && chk_on) begin
			if (t_lf > t_cfg) check(cyc - t_lf, (line_start_wait + 2) * tpix);
			t_fr = cyc;
			fs_pend = 1;
		end
		if (cap_valid && chk_on) begin
			if (zero_pend > 0) begin
				zero_pend--;
				check(cap_data, 8'h00);
			end else check(cap_data, exp_q.pop_front());
			if (fs_pend) check(cyc - t_fr <= ts, 1'b1);
			if (t_sr > t_lr && t_sr > t_cfg) check(cyc - t_sr, ts);
			fs_pend = 0;
			t_sr = cyc;
		end
		// shift idle in sync gaps, data move only while shift is inactive
		if (chk_on && (line_sync ^ pol[1]) && (shift_clk ^ pol[0])) check(1'b1, 1'b0);
		if (chk_on && panel_data_bus !== last_data && (shift_clk ^ pol[0])) check(1'b1, 1'b0);
		last_data = panel_data_bus;
	end

	initial begin
		step(4);
		resetn = 1'b1;
		run_cfg(1500);
		// Walk every bus width with random waits, lengths and polarities
		for (int i = 0; i < 4; i++) begin
			bus_width_sel = i[1:0];
			periph_div = 4'h1 + 4'($random(seed) & 1);
			// Keep every random setting inside the shift clock limit
			pixel_clock_divider = (i == 0) ? 6'h02 : (i == 1) ? 6'h01 : 6'($random(seed) & 1);
			line_end_wait = 8'($random(seed) & 7);
			line_start_wait = 8'($random(seed) & 7);
			line_sync_width = 8'($random(seed) & 7);
			line_groups = 10'($random(seed) & 7);
			frame_lines = 10'($random(seed) & 1);
			pol = 3'($random(seed));
			run_cfg(3000);
		end
		// clock limits at and around their boundaries
		foreach (lim[i]) begin
			{periph_div, pixel_clock_divider, bus_width_sel} = lim[i][12:1];
			enable = 1'b1;
			step(3);
			check(cfg_err, lim[i][0]);
			enable = 1'b0;
			step(2);
		end
		report_and_stop();
	end
endmodule : tb_top
